// ===== iwd_decoder.sv
// Instruction word decoder: word pairing, extension flagging and skip cost
`timescale 1ns/1ps
`include "iwd_defines.svh"
module iwd_decoder
  import iwd_pkg::*;
(
  input wire logic clk_sys_in,                       // System clock
  input wire logic rst_b_in,                         // Asynchronous reset, active low
  input wire logic fetch_valid_in,                   // Fetched word present this cycle
  input wire logic [`IWD_WORD_W-1:0] fetch_word_in,  // Fetched program word
  input wire logic flush_in,                         // Program flow redirected
  output iwd_result_t result_out,                    // Decoded instruction, valid one cycle
  output logic ext_word_out,                         // Fetch consumed as extension word
  output iwd_skip_cost_t skip_cost_out               // Cost of a taken skip, valid one cycle
);

  typedef enum logic {
    ST_FIRST,
    ST_EXT
  } iwd_state_t;

  typedef struct packed {
    iwd_state_t state;
    iwd_decode_t held;
    logic skip_pending;
    iwd_result_t result;
    logic ext_word;
    iwd_skip_cost_t skip_cost;
  } iwd_dec_state_t;

  iwd_dec_state_t st_reg;
  iwd_dec_state_t st_next;
  iwd_decode_t word_dec;

  iwd_field_extract u_extract (
    .word_in (fetch_word_in),
    .dec_out (word_dec)
  );

  always_comb begin
    st_next = st_reg;
    st_next.result.valid = 1'b0;
    st_next.ext_word = 1'b0;
    st_next.skip_cost.valid = 1'b0;
    if (flush_in) begin
      // A redirect drops any half-built pair; a landing on a second word then decodes as a no-op
      st_next.state = ST_FIRST; // RULE5
      st_next.skip_pending = 1'b0;
    end else if (fetch_valid_in) begin
      unique case (st_reg.state)
        ST_FIRST: begin
          if (st_reg.skip_pending) begin
            st_next.skip_cost.valid = 1'b1;
            st_next.skip_cost.cycles = word_dec.two_word ? `IWD_CYC_THREE : `IWD_CYC_TWO; // RULE17
          end
          st_next.skip_pending = word_dec.is_skip;
          if (word_dec.two_word) begin
            st_next.held = word_dec; // RULE3
            st_next.state = ST_EXT;
          end else begin
            st_next.result.valid = 1'b1; // RULE1
            st_next.result.dec = word_dec;
          end
        end
        ST_EXT: begin
          st_next.ext_word = 1'b1; // RULE19
          st_next.state = ST_FIRST;
          st_next.result.valid = 1'b1; // RULE3
          st_next.result.dec = st_reg.held;
          st_next.result.dec.ops.ext_data = fetch_word_in[`IWD_EXT_DATA_HI:`IWD_EXT_DATA_LO]; // RULE4
          st_next.result.dec.ops.prog_addr = {fetch_word_in[`IWD_ADDR_HI_HI:`IWD_ADDR_HI_LO],
                                              st_reg.held.ops.prog_addr[15:0]}; // RULE4
          st_next.result.dec.cycles = `IWD_CYC_TWO; // RULE6
          st_next.result.dec.cycles_taken = `IWD_CYC_TWO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // All-zero state is ST_FIRST with every output low
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result_out = st_reg.result;
  assign ext_word_out = st_reg.ext_word;
  assign skip_cost_out = st_reg.skip_cost;

endmodule : iwd_decoder

// ===== iwd_decoder_chk.sv
// Port assertions for the instruction word decoder
`timescale 1ns/1ps
module iwd_decoder_chk
  import iwd_pkg::*;
(
  input wire logic clk_sys_in, // Clock
  input wire logic rst_b_in, // Reset
  input wire logic fetch_valid_in, // Word present
  input wire logic [23:0] fetch_word_in, // Word
  input wire logic flush_in, // Redirect
  input iwd_result_t result_out, // Result
  input wire logic ext_word_out, // Extension flag
  input iwd_skip_cost_t skip_cost_out // Skip cost
);
  logic acc, dbl, pend_reg, skip_reg;
  logic [7:0] opc;
  logic [15:0] low_reg;
  logic [22:0] join_w;
  iwd_decode_t d;
  assign d = result_out.dec;
  assign acc = fetch_valid_in && !flush_in;
  assign opc = fetch_word_in[23:16];
  assign dbl = opc inside {8'h02, 8'h04, 8'h08};
  assign join_w = {fetch_word_in[6:0], low_reg};
  // Tracks a pending pair and a pending skip as the ports show them
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_reg <= 1'b0;
      skip_reg <= 1'b0;
      low_reg <= 16'h0000;
    end else begin
      pend_reg <= flush_in ? 1'b0 : (acc ? !pend_reg && dbl : pend_reg);
      skip_reg <= flush_in ? 1'b0 : (acc ? !pend_reg && opc inside {8'h0c, 8'h0d} : skip_reg);
      low_reg <= acc ? fetch_word_in[15:0] : low_reg;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  single_word_a: assert property (acc && !pend_reg && !dbl |=> result_out.valid && !ext_word_out
    && d.opcode == $past(opc)) else $error("single word result wrong");
  pair_wait_a: assert property (acc && !pend_reg && dbl |=> !result_out.valid) else $error("early pair result");
  pair_done_a: assert property (acc && pend_reg |=> result_out.valid && ext_word_out && d.two_word)
    else $error("pair result missing");
  pair_cost_a: assert property (ext_word_out |-> d.cycles == 2'h2 && d.cycles_taken == 2'h2)
    else $error("pair cycle count wrong");
  addr_join_a: assert property (acc && pend_reg |=> d.ops.prog_addr == $past(join_w))
    else $error("joined address wrong");
  lone_nop_a: assert property (result_out.valid && !ext_word_out && d.opcode == 8'h00
    |-> d.is_nop && d.cycles == 2'h1) else $error("lone second word not a no-op");
  dsp_class_a: assert property (result_out.valid && d.opcode[7:5] == 3'h7 |-> d.cls == IWD_CLS_DSP)
    else $error("signal class wrong");
  cond_cost_a: assert property (result_out.valid && d.opcode == 8'h03
    |-> d.cycles == 2'h1 && d.cycles_taken == 2'h2) else $error("conditional cost wrong");
  return_cost_a: assert property (result_out.valid && d.opcode inside {8'h06, 8'h07} |-> d.cycles == 2'h3)
    else $error("return cost wrong");
  skip_cost_a: assert property (acc && skip_reg |=> skip_cost_out.valid
    && skip_cost_out.cycles == ($past(dbl) ? 2'h3 : 2'h2)) else $error("skip cost wrong");
  flush_drop_a: assert property (fetch_valid_in && flush_in |=> !result_out.valid && !ext_word_out)
    else $error("flushed word decoded");
endmodule : iwd_decoder_chk
bind iwd_decoder iwd_decoder_chk chk_u (.clk_sys_in, .rst_b_in, .fetch_valid_in, .fetch_word_in, .flush_in,
  .result_out, .ext_word_out, .skip_cost_out);

// ===== iwd_defines.svh
// Constants for the instruction word decoder
// Function
// [RULE1] A normal instruction is one 24-bit program word, decoded as one unit.
// [RULE2] Single words split into an 8-bit opcode plus operand fields.
// [RULE3] Exactly three opcodes span two words; both are fetched before dispatch.
// [RULE4] Two-word instructions carry 48 bits; second word top 8 bits are zero.
// [RULE5] A second word executed alone is decoded as a no-operation.
// [RULE6] Every two-word instruction takes two instruction cycles.
// [RULE7] Single words take one cycle; two when condition true or PC changes.
// [RULE8] Instructions sort into word/byte, bit, literal, DSP and control classes.
// [RULE9] Working-register word/byte ops decode base, source and destination operands.
// [RULE10] File-register ops decode file address and file-or-working-zero destination.
// [RULE11] Bit ops target register or file; bit from literal or base register.
// [RULE12] Literal arithmetic ops decode base, literal, optional separate destination.
// [RULE13] MAC ops decode accumulator, multiplier pair, X/Y prefetch, write-back.
// [RULE14] Other DSP ops decode accumulator, operand with modifier, shift amount.
// [RULE15] Control ops decode program address and/or table mode.
// [RULE16] Branch, indirect call/jump, table ops and returns take two or three cycles.
// [RULE17] Taken skip costs two cycles over one word, three over two words.
// [RULE18] Double-word data moves take two instruction cycles.
// [RULE19] The fetch after a two-word opcode is flagged as extension, not dispatched.
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH

`define IWD_WORD_W 24
`define IWD_OPC_HI 23
`define IWD_OPC_LO 16
`define IWD_OPC_NOP 8'h00
`define IWD_OPC_BRANCH 8'h01
`define IWD_OPC_CALL_LONG 8'h02
`define IWD_OPC_COND_BRANCH 8'h03
`define IWD_OPC_GOTO_LONG 8'h04
`define IWD_OPC_INDIRECT 8'h05
`define IWD_OPC_RETURN 8'h06
`define IWD_OPC_INT_RETURN 8'h07
`define IWD_OPC_LOOP_LONG 8'h08
`define IWD_OPC_TABLE_RD 8'h0a
`define IWD_OPC_TABLE_WR 8'h0b
`define IWD_OPC_SKIP_CLR 8'h0c
`define IWD_OPC_SKIP_SET 8'h0d
`define IWD_OPC_MOVE_DBL 8'h0e
// Class selected by opcode bits 7:5 (control is 000)
`define IWD_GRP_CTRL 3'h0
`define IWD_GRP_LIT_A 3'h1
`define IWD_GRP_LIT_B 3'h2
`define IWD_GRP_WORKING_REG_ZERO_ALIAS_A 3'h3
`define IWD_GRP_WORKING_REG_ZERO_ALIAS_B 3'h4
`define IWD_GRP_BIT 3'h5
`define IWD_GRP_FILE 3'h6
`define IWD_GRP_DSP 3'h7
`define IWD_DSP_MAC_BIT 4
// Operand field positions inside the first word; the last four lie in the second word
`define IWD_BASE_HI 18
`define IWD_BASE_LO 15
`define IWD_BYTE_BIT 14
`define IWD_DMODE_HI 13
`define IWD_DMODE_LO 11
`define IWD_DREG_HI 10
`define IWD_DREG_LO 7
`define IWD_SMODE_HI 6
`define IWD_SMODE_LO 4
`define IWD_SREG_HI 3
`define IWD_SREG_LO 0
`define IWD_FDIR_BIT 13
`define IWD_FADDR_HI 12
`define IWD_FADDR_LO 0
`define IWD_BITPOS_HI 15
`define IWD_BITPOS_LO 12
`define IWD_BITIND_BIT 11
`define IWD_LIT_HI 14
`define IWD_LIT_LO 4
`define IWD_SEPDST_BIT 15
`define IWD_ACC_BIT 15
`define IWD_MPAIR_HI 14
`define IWD_MPAIR_LO 12
`define IWD_XPF_HI 11
`define IWD_XPF_LO 8
`define IWD_XDST_HI 7
`define IWD_XDST_LO 6
`define IWD_YPF_HI 5
`define IWD_YPF_LO 2
`define IWD_YDST_HI 1
`define IWD_YDST_LO 0
`define IWD_AWB_BIT 14
`define IWD_SHREG_HI 14
`define IWD_SHREG_LO 11
`define IWD_SHBYREG_BIT 10
`define IWD_TMODE_HI 15
`define IWD_TMODE_LO 14
`define IWD_ADDR_LO_HI 15
`define IWD_ADDR_LO_LO 0
`define IWD_ADDR_HI_HI 6
`define IWD_ADDR_HI_LO 0
`define IWD_EXT_DATA_HI 15
`define IWD_EXT_DATA_LO 0
// Cycle counts
`define IWD_CYC_ONE 2'h1
`define IWD_CYC_TWO 2'h2
`define IWD_CYC_THREE 2'h3

`endif

// ===== iwd_fetch_model.sv
// Fetch stage model that presents program words to the decoder
`timescale 1ns/1ps
module iwd_fetch_model (
  input wire logic clk_sys_in, // Clock
  input wire logic req_in, // Present a word
  input wire logic [23:0] word_in, // Word to present
  input wire logic redirect_in, // Redirect request
  output logic valid_out, // Word present
  output logic [23:0] word_out, // Word to decoder
  output logic flush_out // Redirect to decoder
);
  initial begin
    valid_out = 1'b0;
    word_out = 24'h000000;
    flush_out = 1'b0;
  end
  always @(negedge clk_sys_in) begin
    valid_out <= req_in;
    flush_out <= redirect_in;
    // Idle bus inverts the last word on each idle cycle
    word_out <= req_in ? word_in : ~word_out;
  end
endmodule : iwd_fetch_model

// ===== iwd_field_extract.sv
// Combinational opcode classification and operand extraction for one word
`timescale 1ns/1ps
`include "iwd_defines.svh"
module iwd_field_extract
  import iwd_pkg::*;
(
  input wire logic [`IWD_WORD_W-1:0] word_in, // Program word
  output iwd_decode_t dec_out                  // Decoded first word
);

  function automatic logic is_long_op(input logic [7:0] op);
    return (op == `IWD_OPC_CALL_LONG) || (op == `IWD_OPC_GOTO_LONG) || (op == `IWD_OPC_LOOP_LONG);
  endfunction : is_long_op

  logic [7:0] opc;
  logic [2:0] grp;

  assign opc = word_in[`IWD_OPC_HI:`IWD_OPC_LO]; // RULE2
  assign grp = opc[7:5];

  always_comb begin
    dec_out = '0;
    dec_out.opcode = opc;
    dec_out.cycles = `IWD_CYC_ONE; // RULE1 RULE7
    dec_out.cycles_taken = `IWD_CYC_ONE;
    unique case (grp)
      `IWD_GRP_CTRL: dec_out.cls = IWD_CLS_CTRL;
      `IWD_GRP_LIT_A, `IWD_GRP_LIT_B: dec_out.cls = IWD_CLS_LIT;
      `IWD_GRP_WORKING_REG_ZERO_ALIAS_A, `IWD_GRP_WORKING_REG_ZERO_ALIAS_B, `IWD_GRP_FILE: dec_out.cls = IWD_CLS_WORD;
      `IWD_GRP_BIT: dec_out.cls = IWD_CLS_BIT;
      `IWD_GRP_DSP: dec_out.cls = IWD_CLS_DSP; // RULE8
    endcase
    // Register triple for word/byte working-register forms
    dec_out.ops.base_reg_operand = word_in[`IWD_BASE_HI:`IWD_BASE_LO]; // RULE9
    dec_out.ops.byte_mode = word_in[`IWD_BYTE_BIT];
    dec_out.ops.dest_mode = word_in[`IWD_DMODE_HI:`IWD_DMODE_LO];
    dec_out.ops.dest_reg_operand = word_in[`IWD_DREG_HI:`IWD_DREG_LO];
    dec_out.ops.src_mode = word_in[`IWD_SMODE_HI:`IWD_SMODE_LO];
    dec_out.ops.source_reg_operand = word_in[`IWD_SREG_HI:`IWD_SREG_LO];
    unique case (grp)
      `IWD_GRP_FILE, `IWD_GRP_BIT: begin
        dec_out.ops.file_addr = word_in[`IWD_FADDR_HI:`IWD_FADDR_LO]; // RULE10
        dec_out.ops.to_working_reg_zero_alias = (grp == `IWD_GRP_FILE) && !word_in[`IWD_FDIR_BIT];
        dec_out.ops.bit_pos = word_in[`IWD_BITPOS_HI:`IWD_BITPOS_LO]; // RULE11
        dec_out.ops.bit_indirect = (grp == `IWD_GRP_BIT) && word_in[`IWD_BITIND_BIT];
      end
      `IWD_GRP_LIT_A, `IWD_GRP_LIT_B: begin
        dec_out.ops.literal = word_in[`IWD_LIT_HI:`IWD_LIT_LO]; // RULE12
        dec_out.ops.src_mode = '0;
        dec_out.ops.sep_dest = word_in[`IWD_SEPDST_BIT];
        if (!word_in[`IWD_SEPDST_BIT]) begin
          dec_out.ops.dest_reg_operand = word_in[`IWD_BASE_HI:`IWD_BASE_LO];
          dec_out.ops.dest_mode = '0;
        end
      end
      `IWD_GRP_DSP: begin
        dec_out.ops.dsp_mac = opc[`IWD_DSP_MAC_BIT];
        dec_out.ops.acc_sel = word_in[`IWD_ACC_BIT]; // RULE13 RULE14
        if (opc[`IWD_DSP_MAC_BIT]) begin
          dec_out.ops.mult_pair = word_in[`IWD_MPAIR_HI:`IWD_MPAIR_LO]; // RULE13
          dec_out.ops.x_prefetch = word_in[`IWD_XPF_HI:`IWD_XPF_LO];
          dec_out.ops.x_dest = word_in[`IWD_XDST_HI:`IWD_XDST_LO];
          dec_out.ops.y_prefetch = word_in[`IWD_YPF_HI:`IWD_YPF_LO];
          dec_out.ops.y_dest = word_in[`IWD_YDST_HI:`IWD_YDST_LO];
          dec_out.ops.awb = word_in[`IWD_AWB_BIT];
        end else begin
          dec_out.ops.shift_count_reg = word_in[`IWD_SHREG_HI:`IWD_SHREG_LO]; // RULE14
          dec_out.ops.shift_by_reg = word_in[`IWD_SHBYREG_BIT];
          dec_out.ops.literal = {2'h0, word_in[`IWD_SMODE_HI:`IWD_SREG_LO], 2'h0};
        end
      end
      default: begin
        dec_out.ops.file_addr = '0;
      end
    endcase
    if (grp == `IWD_GRP_CTRL) begin
      dec_out.ops.prog_addr = {7'h00, word_in[`IWD_ADDR_LO_HI:`IWD_ADDR_LO_LO]}; // RULE15
      if ((opc == `IWD_OPC_TABLE_RD) || (opc == `IWD_OPC_TABLE_WR)) begin
        dec_out.ops.table_mode = word_in[`IWD_TMODE_HI:`IWD_TMODE_LO]; // RULE15
      end
      dec_out.two_word = is_long_op(opc); // RULE3
      dec_out.is_nop = (opc == `IWD_OPC_NOP); // RULE5
      dec_out.is_skip = (opc == `IWD_OPC_SKIP_CLR) || (opc == `IWD_OPC_SKIP_SET);
      if (is_long_op(opc) || (opc == `IWD_OPC_MOVE_DBL)) begin
        dec_out.cycles = `IWD_CYC_TWO; // RULE6 RULE18
        dec_out.cycles_taken = `IWD_CYC_TWO;
      end
      if ((opc == `IWD_OPC_BRANCH) || (opc == `IWD_OPC_INDIRECT) ||
          (opc == `IWD_OPC_TABLE_RD) || (opc == `IWD_OPC_TABLE_WR)) begin
        dec_out.cycles = `IWD_CYC_TWO; // RULE16
        dec_out.cycles_taken = `IWD_CYC_TWO;
      end
      if ((opc == `IWD_OPC_RETURN) || (opc == `IWD_OPC_INT_RETURN)) begin
        dec_out.cycles = `IWD_CYC_THREE; // RULE16
        dec_out.cycles_taken = `IWD_CYC_THREE;
      end
      if (opc == `IWD_OPC_COND_BRANCH) begin
        dec_out.cycles_taken = `IWD_CYC_TWO; // RULE7
      end
    end
  end

endmodule : iwd_field_extract

// ===== iwd_pkg.sv
// Types shared by the instruction word decoder
package iwd_pkg;

  typedef enum logic [2:0] {
    IWD_CLS_WORD,
    IWD_CLS_BIT,
    IWD_CLS_LIT,
    IWD_CLS_DSP,
    IWD_CLS_CTRL
  } iwd_class_t;

  typedef struct packed {
    logic [3:0] base_reg_operand;
    logic [2:0] src_mode;
    logic [3:0] source_reg_operand;
    logic [2:0] dest_mode;
    logic [3:0] dest_reg_operand;
    logic byte_mode;
    logic sep_dest;
    logic [12:0] file_addr;
    logic to_working_reg_zero_alias;
    logic [3:0] bit_pos;
    logic bit_indirect;
    logic [10:0] literal;
    logic dsp_mac;
    logic acc_sel;
    logic [2:0] mult_pair;
    logic [3:0] x_prefetch;
    logic [1:0] x_dest;
    logic [3:0] y_prefetch;
    logic [1:0] y_dest;
    logic awb;
    logic [3:0] shift_count_reg;
    logic shift_by_reg;
    logic [22:0] prog_addr;
    logic [1:0] table_mode;
    logic [15:0] ext_data;
  } iwd_operands_t;

  typedef struct packed {
    iwd_class_t cls;
    logic [7:0] opcode;
    logic two_word;
    logic is_nop;
    logic is_skip;
    logic [1:0] cycles;
    logic [1:0] cycles_taken;
    iwd_operands_t ops;
  } iwd_decode_t;

  typedef struct packed {
    logic valid;
    iwd_decode_t dec;
  } iwd_result_t;

  typedef struct packed {
    logic valid;
    logic [1:0] cycles;
  } iwd_skip_cost_t;

endpackage : iwd_pkg

// ===== test_instruction_word_decoder.sv
// Self-checking bench for the instruction word decoder
`timescale 1ns/1ps
module test_instruction_word_decoder;
  import iwd_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req = 1'b0;
  logic redir = 1'b0;
  logic [23:0] wd = 24'h000000;
  logic fv, fl, ext;
  logic [23:0] fw;
  iwd_result_t res;
  iwd_skip_cost_t sk;
  iwd_operands_t o;
  int err_count = 0;
  int n_tests = 0;
  assign o = res.dec.ops;
  always #2.5 clk_sys_in = ~clk_sys_in;
  iwd_fetch_model fm_u (.clk_sys_in(clk_sys_in), .req_in(req), .word_in(wd), .redirect_in(redir),
    .valid_out(fv), .word_out(fw), .flush_out(fl));
  iwd_decoder dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .fetch_valid_in(fv), .fetch_word_in(fw),
    .flush_in(fl), .result_out(res), .ext_word_out(ext), .skip_cost_out(sk));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Word is taken at the posedge after the model's negedge; result is read just after it
  task automatic feed(input logic [23:0] w);
    req = 1'b1;
    wd = w;
    @(negedge clk_sys_in);
    @(posedge clk_sys_in);
    #1;
  endtask : feed
  task automatic stop();
    req = 1'b0;
    @(negedge clk_sys_in);
    @(posedge clk_sys_in);
    #1;
  endtask : stop
  task automatic s_classes();
    logic [7:0] op[16] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0e, 8'h20, 8'h40,
      8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0};
    logic [1:0] cy[16] = '{1, 2, 1, 2, 3, 3, 2, 2, 2, 1, 1, 1, 1, 1, 1, 1};
    for (int i = 0; i < 16; i++) begin
      feed({op[i], 16'h0000});
      chk("valid", 1, res.valid);
      chk("class", (i < 9) ? IWD_CLS_CTRL : (i < 11) ? IWD_CLS_LIT : (i == 13) ? IWD_CLS_BIT :
        (i == 15) ? IWD_CLS_DSP : IWD_CLS_WORD, res.dec.cls);
      chk("cycles", cy[i], res.dec.cycles);
      if (i == 0) chk("nop", 1, res.dec.is_nop);
      if (i == 2) chk("taken", 2, res.dec.cycles_taken);
      if (i == 8) chk("dmove", 2, res.dec.cycles_taken);
    end
    stop();
  endtask : s_classes
  task automatic s_fields();
    logic [23:0] w;
    w = 24'h61d2a9;
    feed(w);
    chk("base", w[18:15], o.base_reg_operand);
    chk("byte", w[14], o.byte_mode);
    chk("src", w[6:0], {o.src_mode, o.source_reg_operand});
    chk("dst", w[13:7], {o.dest_mode, o.dest_reg_operand});
    w = 24'hc11abc;
    feed(w);
    chk("file", {w[12:0], 1'b1}, {o.file_addr, o.to_working_reg_zero_alias});
    w = 24'ha0f800;
    feed(w);
    chk("bit", w[15:11], {o.bit_pos, o.bit_indirect});
    w = 24'h2112f0;
    feed(w);
    chk("lit", {w[14:4], 1'b0}, {o.literal, o.sep_dest});
    chk("litdst", {3'h0, w[18:15]}, {o.dest_mode, o.dest_reg_operand});
    w = 24'hf0cde5;
    feed(w);
    chk("mac", w[15:0], {o.acc_sel, o.mult_pair, o.x_prefetch, o.x_dest, o.y_prefetch, o.y_dest});
    chk("mac_kind", {1'b1, w[14]}, {o.dsp_mac, o.awb});
    w = 24'he0c800;
    feed(w);
    chk("shift", w[15:10], {o.acc_sel, o.shift_count_reg, o.shift_by_reg});
    feed(24'h0a8000);
    chk("tmode", 2, o.table_mode);
    stop();
  endtask : s_fields
  task automatic s_pairs();
    logic [7:0] op[3] = '{8'h02, 8'h04, 8'h08};
    logic [23:0] w;
    for (int i = 0; i < 3; i++) begin
      w = 24'h004c71 + i;
      feed({op[i], 16'hbeef});
      chk("early", 0, res.valid);
      if (i == 1) stop();
      feed(w);
      chk("pair", 3'h7, {res.valid, ext, res.dec.two_word});
      chk("cyc", 2, res.dec.cycles);
      chk("addr", {w[6:0], 16'hbeef}, o.prog_addr);
      chk("ext", w[15:0], o.ext_data);
    end
    feed(24'h004c71);
    chk("lone", 2'h3, {res.valid, res.dec.is_nop});
    stop();
  endtask : s_pairs
  task automatic s_skip();
    feed(24'h0c0000);
    chk("skip", 1, res.dec.is_skip);
    feed(24'h040000);
    chk("skip3", 3'h7, {sk.valid, sk.cycles});
    feed(24'h001234);
    feed(24'h0d0000);
    feed(24'h010000);
    chk("skip2", 3'h6, {sk.valid, sk.cycles});
    stop();
  endtask : s_skip
  task automatic s_flush();
    feed(24'h040000);
    redir = 1'b1;
    feed(24'h00aaaa);
    redir = 1'b0;
    chk("flush", 0, {res.valid, ext});
    feed(24'h010000);
    chk("after", 2'h2, {res.valid, ext});
    stop();
  endtask : s_flush
  // Reset in mid-pair must clear outputs and drop the half-built pair
  task automatic s_reset();
    feed(24'h020000);
    req = 1'b0;
    @(negedge clk_sys_in);
    rst_b_in = 1'b0;
    #1;
    chk("rst", 9'h000, {res.valid, res.dec.opcode});
    @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    feed(24'h010000);
    chk("rst_pair", 2'h2, {res.valid, ext});
    stop();
  endtask : s_reset
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (16) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    // Start after a rising edge so the fetch model never races the first request
    @(posedge clk_sys_in);
    #1;
    s_classes();
    s_fields();
    s_pairs();
    s_skip();
    s_flush();
    s_reset();
    close_out();
  end
endmodule : test_instruction_word_decoder
